// file: hdl/sfot_engine.sv
`timescale 1ns/100ps
module sfot_engine #(
   parameter longint CYC_RCE_P = sfot_pkg::CYC_RCE,
   parameter longint CYC_WRSR_P = sfot_pkg::CYC_WRSR,
   parameter longint CYC_SE_P = sfot_pkg::CYC_SE_TYP,
   parameter longint CYC_BE32_P = sfot_pkg::CYC_BE32_TYP,
   parameter longint CYC_BE64_P = sfot_pkg::CYC_BE64_TYP,
   parameter longint CYC_CE_P = sfot_pkg::CYC_CE_TYP
) (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic link_clk_i,
   input wire logic cs_n_i,
   input wire logic si_i,
   output logic write_in_progress_flag_o,
   output logic suspended_o,
   output logic deep_power_down_o,
   output logic ready_o,
   output logic op_done_o
);
   import sfot_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // elaboration checks against the longest times
   if (CYC_WRSR_P > CYC_WRSR || CYC_WRSR_P < 1) begin : g_bad_wrsr
      $error("status write count out of range");
   end
   if (CYC_SE_P > CYC_SE_MAX || CYC_SE_P < 1) begin : g_bad_se
      $error("sector erase count out of range");
   end
   if (CYC_BE32_P > CYC_BE32_MAX || CYC_BE32_P < 1) begin : g_bad_be32
      $error("32k erase count out of range");
   end
   if (CYC_BE64_P > CYC_BE64_MAX || CYC_BE64_P < 1) begin : g_bad_be64
      $error("64k erase count out of range");
   end
   // the count register holds 32 bits, so the chosen chip erase count must fit there
   if (CYC_CE_P > CYC_CE_MAX || CYC_CE_P < 1 || CYC_CE_P > longint'(32'hFFFF_FFFF)) begin : g_bad_ce
      $error("chip erase count out of range");
   end
   if (CYC_RCE_P > CYC_RCE || CYC_RCE_P < 1) begin : g_bad_rce
      $error("erase recovery count out of range");
   end
   if (longint'(CYC_PP_BASE) + longint'(CYC_PP_BYTE) * longint'(PAGE_BYTES) > CYC_PP_MAX) begin : g_bad_pp
      $error("page program exceeds its longest time");
   end

   ////////////////////////////////////////////////////////////////////////////
   // page program duration for n bytes
   function automatic logic [31:0] pp_cycles(input logic [8:0] n);
      logic [31:0] prod;
      prod = 32'(CYC_PP_BYTE * 32'(n));
      return CYC_PP_BASE + prod;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // link side: first bit of a frame restarts the counts
   logic in_frame_reg;
   logic [2:0] bit_cnt_reg, bit_cnt_next;
   logic [9:0] byte_cnt_reg, byte_cnt_next;
   logic [7:0] shift_reg, shift_next;
   logic [7:0] opcode_reg, opcode_next;

   // next values of the shift and count logic
   always_comb begin
      logic [2:0] bc;
      logic [9:0] yc;
      bc = in_frame_reg ? bit_cnt_reg : 3'h0;
      yc = in_frame_reg ? byte_cnt_reg : 10'h000;
      shift_next = {shift_reg[6:0], si_i};
      bit_cnt_next = bc + 3'h1;
      byte_cnt_next = yc;
      opcode_next = opcode_reg;
      if (bc == 3'h7) begin
         if (yc != 10'h3FF) begin
            byte_cnt_next = yc + 10'h001; // saturate on very long frames
         end
         if (yc == 10'h000) begin
            opcode_next = {shift_reg[6:0], si_i};
         end
      end
   end

   // frame marker, cleared while select is high
   always_ff @(posedge link_clk_i or posedge cs_n_i) begin
      if (cs_n_i) begin
         in_frame_reg <= 1'b0;
      end else begin
         in_frame_reg <= 1'b1;
      end
   end

   // counts hold their final value once the link clock stops
   always_ff @(posedge link_clk_i) begin
      bit_cnt_reg <= bit_cnt_next;
      byte_cnt_reg <= byte_cnt_next;
      shift_reg <= shift_next;
      opcode_reg <= opcode_next;
   end

   ////////////////////////////////////////////////////////////////////////////
   // select synchroniser; the frame words are read only after it settles
   logic cs_meta_reg, cs_sync_reg, cs_prev_reg;

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         cs_meta_reg <= 1'b1;
         cs_sync_reg <= 1'b1;
         cs_prev_reg <= 1'b1;
      end else begin
         cs_meta_reg <= cs_n_i;
         cs_sync_reg <= cs_meta_reg;
         cs_prev_reg <= cs_sync_reg;
      end
   end

   logic frame_end;
   logic [8:0] prog_n;
   assign frame_end = cs_sync_reg & ~cs_prev_reg & (byte_cnt_reg != 10'h000);

   // bytes beyond the header, clamped to one page
   always_comb begin
      logic [9:0] d;
      d = 10'h000;
      if (byte_cnt_reg > PP_HDR_BYTES) begin
         d = byte_cnt_reg - PP_HDR_BYTES;
      end
      prog_n = (d > 10'(PAGE_BYTES)) ? PAGE_BYTES : d[8:0];
   end

   ////////////////////////////////////////////////////////////////////////////
   // timing engine
   sfot_state_t state_reg, state_next;
   sfot_op_t kind_reg, kind_next;
   logic [31:0] cnt_reg, cnt_next;
   logic [31:0] lat_reg, lat_next;
   logic wip_reg, wip_next;
   logic susp_reg, susp_next;
   logic dpd_reg, dpd_next;
   logic rdy_reg, rdy_next;
   logic done_reg, done_next;

   // next state of the engine
   always_comb begin
      state_next = state_reg;
      kind_next = kind_reg;
      cnt_next = cnt_reg;
      lat_next = (lat_reg != 32'h0000_0000) ? lat_reg - 32'h0000_0001 : lat_reg;
      wip_next = wip_reg;
      susp_next = susp_reg;
      dpd_next = dpd_reg;
      rdy_next = rdy_reg;
      done_next = 1'b0;
      case (state_reg)
         ST_IDLE: begin
            if (frame_end) begin
               case (opcode_reg)
                  CMD_POWER_DOWN: begin
                     state_next = ST_DPD_ENTER;
                     // window runs from select rising, so the sync delay is taken off
                     lat_next = CYC_DP - CYC_SYNC;
                     rdy_next = 1'b0;
                  end
                  CMD_READ: begin
                     state_next = ST_RECOVER;
                     lat_next = CYC_RCR;
                     rdy_next = 1'b0;
                  end
                  CMD_PAGE_PROG: begin
                     if (prog_n != 9'h000) begin
                        state_next = ST_BUSY;
                        kind_next = OP_PROG;
                        cnt_next = pp_cycles(prog_n);
                        wip_next = 1'b1;
                        rdy_next = 1'b0;
                     end
                  end
                  CMD_STATUS_WRITE: begin
                     state_next = ST_BUSY;
                     kind_next = OP_WRSR;
                     cnt_next = 32'(CYC_WRSR_P);
                     wip_next = 1'b1;
                     rdy_next = 1'b0;
                  end
                  CMD_SECT_ERASE, CMD_BLK32_ERASE, CMD_BLK64_ERASE, CMD_CHIP_ERASE: begin
                     state_next = ST_BUSY;
                     kind_next = OP_ERASE;
                     wip_next = 1'b1;
                     rdy_next = 1'b0;
                     if (opcode_reg == CMD_SECT_ERASE) begin
                        cnt_next = 32'(CYC_SE_P);
                     end else if (opcode_reg == CMD_BLK32_ERASE) begin
                        cnt_next = 32'(CYC_BE32_P);
                     end else if (opcode_reg == CMD_BLK64_ERASE) begin
                        cnt_next = 32'(CYC_BE64_P);
                     end else begin
                        cnt_next = 32'(CYC_CE_P);
                     end
                  end
                  default: begin
                  end
               endcase
            end
         end
         ST_BUSY: begin
            cnt_next = cnt_reg - 32'h0000_0001;
            if (cnt_reg <= 32'h0000_0001) begin
               wip_next = 1'b0;
               done_next = 1'b1;
               susp_next = 1'b0;
               if (kind_reg == OP_WRSR) begin
                  state_next = ST_IDLE;
                  rdy_next = 1'b1;
               end else begin
                  state_next = ST_RECOVER;
                  lat_next = (kind_reg == OP_ERASE) ? 32'(CYC_RCE_P) : CYC_RCP;
               end
               kind_next = OP_NONE;
            end else if (frame_end && opcode_reg == CMD_SUSPEND && kind_reg != OP_WRSR) begin
               state_next = ST_SUSP_WAIT;
               lat_next = CYC_SUSP;
            end
         end
         ST_SUSP_WAIT: begin
            if (lat_reg <= 32'h0000_0001) begin
               state_next = ST_SUSP;
               wip_next = 1'b0;
               susp_next = 1'b1;
            end
         end
         ST_SUSP: begin
            // resume may be suspended again at once, spacing is the host's
            if (frame_end && opcode_reg == CMD_RESUME) begin
               state_next = ST_BUSY;
               wip_next = 1'b1;
               susp_next = 1'b0;
            end
         end
         ST_RECOVER: begin
            if (lat_reg <= 32'h0000_0001) begin
               state_next = ST_IDLE;
               rdy_next = 1'b1;
            end
         end
         ST_DPD_ENTER: begin
            if (lat_reg <= 32'h0000_0001) begin
               state_next = ST_DPD;
               dpd_next = 1'b1;
            end
         end
         ST_DPD: begin
            if (frame_end && opcode_reg == CMD_RELEASE_PD) begin
               state_next = ST_WAKE;
               lat_next = CYC_RES - CYC_SYNC;
            end
         end
         ST_WAKE: begin
            if (lat_reg <= 32'h0000_0001) begin
               state_next = ST_IDLE;
               dpd_next = 1'b0;
               rdy_next = 1'b1;
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   // engine registers
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         state_reg <= ST_IDLE;
         kind_reg <= OP_NONE;
         cnt_reg <= 32'h0000_0000;
         lat_reg <= 32'h0000_0000;
         wip_reg <= 1'b0;
         susp_reg <= 1'b0;
         dpd_reg <= 1'b0;
         rdy_reg <= 1'b1;
         done_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         kind_reg <= kind_next;
         cnt_reg <= cnt_next;
         lat_reg <= lat_next;
         wip_reg <= wip_next;
         susp_reg <= susp_next;
         dpd_reg <= dpd_next;
         rdy_reg <= rdy_next;
         done_reg <= done_next;
      end
   end

   // outputs straight from flip-flops
   assign write_in_progress_flag_o = wip_reg;
   assign suspended_o = susp_reg;
   assign deep_power_down_o = dpd_reg;
   assign ready_o = rdy_reg;
   assign op_done_o = done_reg;
endmodule

// file: hdl/sfot_pkg.sv
package sfot_pkg;
   ////////////////////////////////////////////////////////////////////////////
   // clock of the timing engine
   localparam real CLK_PERIOD_NS = 10.0;
   // command codes recognised in the first byte of a frame
   localparam logic [7:0] CMD_PAGE_PROG = 8'h02;
   localparam logic [7:0] CMD_SECT_ERASE = 8'h20;
   localparam logic [7:0] CMD_BLK32_ERASE = 8'h52;
   localparam logic [7:0] CMD_BLK64_ERASE = 8'hD8;
   localparam logic [7:0] CMD_CHIP_ERASE = 8'h60;
   localparam logic [7:0] CMD_STATUS_WRITE = 8'h01;
   localparam logic [7:0] CMD_POWER_DOWN = 8'hB9;
   localparam logic [7:0] CMD_RELEASE_PD = 8'hAB;
   localparam logic [7:0] CMD_SUSPEND = 8'hB0;
   localparam logic [7:0] CMD_RESUME = 8'h30;
   localparam logic [7:0] CMD_READ = 8'h03;
   // frame layout of a page program: opcode plus three address bytes
   localparam logic [9:0] PP_HDR_BYTES = 10'h004;
   localparam logic [8:0] PAGE_BYTES = 9'h100;
   // times in their printed units
   localparam real T_DP_US = 10.0;
   localparam real T_RES_US = 30.0;
   localparam real T_RCR_US = 20.0;
   localparam real T_RCP_US = 20.0;
   localparam real T_RCE_MS = 12.0;
   localparam real T_WRSR_MS = 40.0;
   localparam real T_PP_BASE_MS = 0.008;
   localparam real T_PP_BYTE_MS = 0.004;
   localparam real T_PP_MAX_MS = 3.0;
   localparam real T_SE_TYP_MS = 35.0;
   localparam real T_SE_MAX_MS = 200.0;
   localparam real T_BE32_TYP_S = 0.2;
   localparam real T_BE32_MAX_S = 1.0;
   localparam real T_BE64_TYP_S = 0.35;
   localparam real T_BE64_MAX_S = 2.0;
   localparam real T_CE_TYP_S = 25.0;
   localparam real T_CE_MAX_S = 50.0;
   localparam real T_SUSP_US = 20.0;
   // cycle counts, longest times rounded down
   localparam logic [31:0] CYC_DP = 32'($floor(T_DP_US * 1.0e3 / CLK_PERIOD_NS));
   localparam logic [31:0] CYC_RES = 32'($floor(T_RES_US * 1.0e3 / CLK_PERIOD_NS));
   localparam logic [31:0] CYC_RCR = 32'($floor(T_RCR_US * 1.0e3 / CLK_PERIOD_NS));
   localparam logic [31:0] CYC_RCP = 32'($floor(T_RCP_US * 1.0e3 / CLK_PERIOD_NS));
   localparam logic [31:0] CYC_SUSP = 32'($floor(T_SUSP_US * 1.0e3 / CLK_PERIOD_NS));
   localparam logic [31:0] CYC_PP_BASE = 32'($floor(T_PP_BASE_MS * 1.0e6 / CLK_PERIOD_NS));
   localparam logic [31:0] CYC_PP_BYTE = 32'($floor(T_PP_BYTE_MS * 1.0e6 / CLK_PERIOD_NS));
   // system edges from select rising to the engine acting, rounded up
   localparam logic [31:0] CYC_SYNC = 32'h0000_0004;
   localparam longint CYC_RCE = longint'($floor(T_RCE_MS * 1.0e6 / CLK_PERIOD_NS));
   localparam longint CYC_WRSR = longint'($floor(T_WRSR_MS * 1.0e6 / CLK_PERIOD_NS));
   localparam longint CYC_PP_MAX = longint'($floor(T_PP_MAX_MS * 1.0e6 / CLK_PERIOD_NS));
   localparam longint CYC_SE_TYP = longint'($floor(T_SE_TYP_MS * 1.0e6 / CLK_PERIOD_NS));
   localparam longint CYC_SE_MAX = longint'($floor(T_SE_MAX_MS * 1.0e6 / CLK_PERIOD_NS));
   localparam longint CYC_BE32_TYP = longint'($floor(T_BE32_TYP_S * 1.0e9 / CLK_PERIOD_NS));
   localparam longint CYC_BE32_MAX = longint'($floor(T_BE32_MAX_S * 1.0e9 / CLK_PERIOD_NS));
   localparam longint CYC_BE64_TYP = longint'($floor(T_BE64_TYP_S * 1.0e9 / CLK_PERIOD_NS));
   localparam longint CYC_BE64_MAX = longint'($floor(T_BE64_MAX_S * 1.0e9 / CLK_PERIOD_NS));
   localparam longint CYC_CE_TYP = longint'($floor(T_CE_TYP_S * 1.0e9 / CLK_PERIOD_NS));
   localparam longint CYC_CE_MAX = longint'($floor(T_CE_MAX_S * 1.0e9 / CLK_PERIOD_NS));
   ////////////////////////////////////////////////////////////////////////////
   // engine states, one-hot
   typedef enum logic [7:0] {
      ST_IDLE = 8'h01,
      ST_BUSY = 8'h02,
      ST_SUSP_WAIT = 8'h04,
      ST_SUSP = 8'h08,
      ST_RECOVER = 8'h10,
      ST_DPD_ENTER = 8'h20,
      ST_DPD = 8'h40,
      ST_WAKE = 8'h80
   } sfot_state_t;
   // kind of the array operation in flight
   typedef enum logic [1:0] {
      OP_NONE = 2'h0,
      OP_PROG = 2'h1,
      OP_ERASE = 2'h2,
      OP_WRSR = 2'h3
   } sfot_op_t;
endpackage

// file: sim/sfot_props.sv
`timescale 1ns/100ps
module sfot_props #(
   parameter longint CYC_RCE_P = 1200000
) (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic link_clk_i,
   input wire logic cs_n_i,
   input wire logic si_i,
   input wire logic write_in_progress_flag_o,
   input wire logic suspended_o,
   input wire logic deep_power_down_o,
   input wire logic ready_o,
   input wire logic op_done_o
);
   localparam int REC_LIM = (CYC_RCE_P > 3000) ? int'(CYC_RCE_P) : 3000;
   logic [31:0] idle_reg, idle_next, sel_reg, sel_next;
   ////////////////////////////////////////
   // cycles waiting with no flag shown; cycles since select rose
   always_comb begin
      idle_next = 32'h0000_0000;
      sel_next = 32'h0000_0000;
      if (!ready_o && !write_in_progress_flag_o && !suspended_o && !deep_power_down_o) begin
         idle_next = idle_reg + 32'h0000_0001;
      end
      if (cs_n_i) begin
         sel_next = sel_reg + 32'h0000_0001;
      end
   end
   always_ff @(posedge clk_sys_i) begin
      idle_reg <= rst_n_i ? idle_next : 32'h0000_0000;
      sel_reg <= rst_n_i ? sel_next : 32'h0000_0000;
   end
   ////////////////////////////////////////
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);
   a_done_after_busy: assert property (op_done_o |-> $past(write_in_progress_flag_o) && !write_in_progress_flag_o)
      else $error("done without a finished busy period");
   a_done_single_cycle: assert property (op_done_o |=> !op_done_o)
      else $error("done longer than one cycle");
   a_busy_not_ready: assert property (write_in_progress_flag_o |-> !ready_o)
      else $error("ready while busy");
   a_dpd_quiet: assert property (deep_power_down_o |-> !ready_o && !write_in_progress_flag_o)
      else $error("active while powered down");
   a_dpd_entry_time: assert property ($rose(deep_power_down_o) |-> sel_reg <= sfot_pkg::CYC_DP)
      else $error("power-down entry too slow");
   a_wake_time: assert property ($fell(deep_power_down_o) |-> ready_o && sel_reg <= sfot_pkg::CYC_RES)
      else $error("wake too slow or not ready");
   a_susp_time: assert property ($rose(suspended_o) |-> !write_in_progress_flag_o && sel_reg <= 32'h0000_07D6)
      else $error("suspend latency exceeded");
   a_resume_busy: assert property ($fell(suspended_o) |-> write_in_progress_flag_o)
      else $error("resume without busy");
   a_recover_bound: assert property (idle_reg <= REC_LIM)
      else $error("recovery too long");
endmodule
bind sfot_engine sfot_props #(.CYC_RCE_P(CYC_RCE_P)) u_sfot_props (
   .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .link_clk_i(link_clk_i), .cs_n_i(cs_n_i), .si_i(si_i),
   .write_in_progress_flag_o(write_in_progress_flag_o), .suspended_o(suspended_o),
   .deep_power_down_o(deep_power_down_o), .ready_o(ready_o), .op_done_o(op_done_o));

// file: sim/sfot_host.sv
`timescale 1ns/100ps
module sfot_host #(
   parameter real HALF_NS = 32.0,
   parameter real PWRUP_NS = 800000.0,
   parameter real GAP_NS = 300.0
) (
   output logic cs_n_o,
   output logic link_clk_o,
   output logic si_o
);
   import sfot_pkg::*;
   logic up_ok;
   realtime last_resume;
   ////////////////////////////////////////
   // select held high through the power-up wait
   initial begin
      link_clk_o = 1'b0;
      si_o = 1'b0;
      up_ok = 1'b0;
      last_resume = 0.0;
      // select rises after time zero so the frame marker sees a clearing edge
      #1 cs_n_o = 1'b1;
      #(PWRUP_NS);
      up_ok = 1'b1;
   end
   // opcode then fill bytes, msb first; clock still outside frames
   task automatic frame(input logic [7:0] op, input int extra);
      logic [7:0] b;
      wait (up_ok);
      if (op == CMD_SUSPEND) begin
         while ($realtime - last_resume < GAP_NS) #1;
      end
      #7 cs_n_o = 1'b0;
      for (int i = 0; i <= extra; i++) begin
         b = (i == 0) ? op : 8'h5A;
         for (int k = 7; k >= 0; k--) begin
            si_o = b[k];
            #(HALF_NS) link_clk_o = 1'b1;
            #(HALF_NS) link_clk_o = 1'b0;
         end
      end
      #(HALF_NS) cs_n_o = 1'b1;
      si_o = ~si_o; // released line shows no stale bit
      if (op == CMD_RESUME) last_resume = $realtime;
      #100;
   endtask
endmodule

// file: sim/sfot_engine_bench.sv
`timescale 1ns/100ps
module sfot_engine_bench;
   import sfot_pkg::*;
   typedef struct {
      logic [7:0] op;
      int extra;
      int busy;
      int rec;
      int done;
   } sfot_row_t;
   localparam longint RCE = 300;
   localparam longint CE = 6000;
   logic clk_sys_i = 1'b0;
   logic rst_n_i = 1'b0;
   wire cs_n, link_clk, si;
   logic write_in_progress_flag, susp, dpd, rdy, done;
   int num_errors = 0;
   int num_checks = 0;
   int cycles = 0;
   int w, r, d, c;
   sfot_row_t rows[8];
   sfot_engine #(.CYC_RCE_P(RCE), .CYC_WRSR_P(200), .CYC_SE_P(100), .CYC_BE32_P(120),
      .CYC_BE64_P(140), .CYC_CE_P(CE)) u_sfot_engine (
      .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .link_clk_i(link_clk), .cs_n_i(cs_n), .si_i(si),
      .write_in_progress_flag_o(write_in_progress_flag), .suspended_o(susp), .deep_power_down_o(dpd),
      .ready_o(rdy), .op_done_o(done));
   sfot_host #(.PWRUP_NS(2000.0)) u_sfot_host (.cs_n_o(cs_n), .link_clk_o(link_clk), .si_o(si));
   ////////////////////////////////////////
   // clock and run limit
   always #5 clk_sys_i = ~clk_sys_i;
   always @(posedge clk_sys_i) begin
      cycles++;
      if (cycles == 90000) begin
         num_errors++;
         conclude();
      end
   end
   ////////////////////////////////////////
   task automatic conclude();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   function automatic logic pick(input int sel);
      return (sel == 0) ? rdy : (sel == 1) ? write_in_progress_flag : (sel == 2) ? susp : dpd;
   endfunction
   // cycles until the chosen flag shows val
   task automatic count_to(input int sel, input logic val, output int n);
      n = 0;
      while (pick(sel) !== val && n < 20000) begin
         @(negedge clk_sys_i);
         n++;
      end
   endtask
   // a frame, counted from select rising
   task automatic timed(input logic [7:0] op, input int extra, input int sel, input logic val,
      output int n);
      fork
         u_sfot_host.frame(op, extra);
         begin
            @(posedge cs_n);
            count_to(sel, val, n);
         end
      join
   endtask
   ////////////////////////////////////////
   initial begin
      rows[0] = '{CMD_PAGE_PROG, 4, int'(CYC_PP_BASE + CYC_PP_BYTE), int'(CYC_RCP), 1};
      rows[1] = '{CMD_PAGE_PROG, 5, int'(CYC_PP_BASE + 2 * CYC_PP_BYTE), int'(CYC_RCP), 1};
      rows[2] = '{CMD_SECT_ERASE, 3, 100, int'(RCE), 1};
      rows[3] = '{CMD_BLK32_ERASE, 3, 120, int'(RCE), 1};
      rows[4] = '{CMD_BLK64_ERASE, 3, 140, int'(RCE), 1};
      rows[5] = '{CMD_CHIP_ERASE, 0, int'(CE), int'(RCE), 1};
      rows[6] = '{CMD_STATUS_WRITE, 1, 200, 0, 1};
      rows[7] = '{CMD_READ, 3, 0, int'(CYC_RCR), 0};
      repeat (10) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      @(negedge clk_sys_i);
      check("reset flags", {write_in_progress_flag, susp, dpd, rdy, done}, 5'h02);
      // each row: busy length, done pulse, then recovery; next frame only once ready
      for (int i = 0; i < 8; i++) begin
         fork
            u_sfot_host.frame(rows[i].op, rows[i].extra);
            begin
               count_to(0, 1'b0, c);
               count_to(1, 1'b0, w);
               d = done;
               count_to(0, 1'b1, r);
            end
         join
         check("busy cycles", w, rows[i].busy);
         check("recovery", r, rows[i].rec);
         check("done pulse", d, rows[i].done);
      end
      // power-down, ignored command, release without and with signature
      for (int v = 0; v < 2; v++) begin
         timed(CMD_POWER_DOWN, 0, 3, 1'b1, c);
         check("dpd entry", c >= CYC_DP - CYC_SYNC && c <= CYC_DP, 1);
         u_sfot_host.frame(CMD_PAGE_PROG, 4);
         repeat (10) @(negedge clk_sys_i);
         check("dpd hold", {write_in_progress_flag, dpd}, 2'h1);
         timed(CMD_RELEASE_PD, 3 * v, 0, 1'b1, c);
         check("wake", c >= CYC_RES - CYC_SYNC && c <= CYC_RES && dpd === 1'b0, 1);
      end
      // suspend, ignored erase, resume, quick second suspend, finish
      timed(CMD_CHIP_ERASE, 0, 1, 1'b1, c);
      timed(CMD_SUSPEND, 0, 2, 1'b1, c);
      check("suspend", c <= CYC_SUSP + 5 && write_in_progress_flag === 1'b0, 1);
      u_sfot_host.frame(CMD_SECT_ERASE, 3);
      repeat (10) @(negedge clk_sys_i);
      check("suspend hold", {write_in_progress_flag, susp}, 2'h1);
      timed(CMD_RESUME, 0, 1, 1'b1, c);
      check("resume", {write_in_progress_flag, susp}, 2'h2);
      timed(CMD_SUSPEND, 0, 2, 1'b1, c);
      check("resuspend", c <= CYC_SUSP + 5, 1);
      timed(CMD_RESUME, 0, 1, 1'b1, c);
      count_to(1, 1'b0, c);
      check("erase finish", c <= CE && done === 1'b1, 1);
      count_to(0, 1'b1, c);
      check("erase recovery", c, RCE);
      // reset in mid erase
      timed(CMD_SECT_ERASE, 3, 1, 1'b1, c);
      @(posedge clk_sys_i);
      rst_n_i <= 1'b0;
      repeat (3) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      @(negedge clk_sys_i);
      check("mid reset", {write_in_progress_flag, susp, dpd, rdy, done}, 5'h02);
      conclude();
   end
endmodule
